// ### hdl/adcc_pkg.sv
// Package: register map, field layout, reset values and types of the converter control block
// Operation
// - Control bit 7: 1 right, 0 left justify
// - Control bit 6: 1 external reference, 0 supply
// - Control bits 3-2 pick analog input 0..3
// - Control bits 5-4 always read zero
// - Writing go starts conversion; reads 1 meanwhile
// - Hardware clears go when conversion ends
// - Converter off gates its clocking entirely
// - Left: high holds 9:2, low 7-6 holds 1:0
// - Right: high 1-0 holds 9:8, low holds 7:0
// - Result registers are never reset
// - Clock select picks /2../64 or RC oscillator
// - Conversion lasts eleven bit periods
// - Completion clears go, sets done, loads result
// - Abort keeps result; two-period holdoff, then acquire
package adcc_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL      = 8'h00;
  localparam logic [7:0] OFF_ANALOG_CLOCK = 8'h04;
  localparam logic [7:0] OFF_RESULT_HIGH  = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h18;

  // Control register fields
  localparam int unsigned CTL_JUSTIFY_BIT = 7;
  localparam int unsigned CTL_REF_BIT     = 6;
  localparam int unsigned CTL_CHAN_LSB    = 2;
  localparam int unsigned CTL_GO_BIT      = 1;
  localparam int unsigned CTL_ON_BIT      = 0;

  // Analog select and clock register fields
  localparam int unsigned ASC_CLK_LSB = 4;
  localparam int unsigned ASC_PIN_LSB = 0;

  localparam int unsigned IRQ_DONE_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] ANALOG_CLOCK_RESET = 8'h0F;

  // Conversion timing in bit periods
  localparam logic [3:0] CONV_BIT_PERIODS  = 4'hB;
  localparam logic [3:0] ABORT_BIT_PERIODS = 4'h2;
  localparam logic [3:0] CONV_LAST         = CONV_BIT_PERIODS - 4'h1;
  localparam logic [3:0] ABORT_LAST        = ABORT_BIT_PERIODS - 4'h1;
  localparam logic [9:0] TRIAL_START       = 10'h200;

  // Divider terminal counts, system clock cycles per bit period minus one
  localparam logic [5:0] DIV2_LAST  = 6'h01;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV8_LAST  = 6'h07;
  localparam logic [5:0] DIV16_LAST = 6'h0F;
  localparam logic [5:0] DIV32_LAST = 6'h1F;
  localparam logic [5:0] DIV64_LAST = 6'h3F;
  localparam logic [1:0] CLK_SEL_RC = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_CONV = 3'b010,
    ADCC_HOLD = 3'b100
  } adcc_state_e;

  typedef struct packed {
    logic       result_justify;
    logic       reference_select;
    logic [1:0] channel_select;
    logic       converter_on;
  } adcc_ctrl_s;

  typedef struct packed {
    logic       converter_on;
    logic       sample_hold;
    logic       reference_select;
    logic [1:0] channel_select;
    logic [9:0] trial_code;
  } adcc_afe_s;

endpackage

// ### hdl/adcc_bit_period.sv
// Bit period tick generator: divided system clock or synchronised RC oscillator
`timescale 1ns/1ps
`default_nettype none
module adcc_bit_period (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] conv_clock_select,
  input  wire logic       rc_osc_pin,
  output logic            bit_tick
);
  import adcc_pkg::*;

  logic [5:0] div_cnt_ff;
  logic       rc_meta_ff;
  logic       rc_sync_ff;
  logic       rc_last_ff;
  logic       tick_ff;
  logic       use_rc;
  logic [5:0] div_end;

  function automatic logic [5:0] div_last(input logic [2:0] sel);
    case (sel)
      3'b000:  div_last = DIV2_LAST;
      3'b100:  div_last = DIV4_LAST;
      3'b001:  div_last = DIV8_LAST;
      3'b101:  div_last = DIV16_LAST;
      3'b010:  div_last = DIV32_LAST;
      3'b110:  div_last = DIV64_LAST;
      default: div_last = DIV2_LAST;
    endcase
  endfunction

  assign use_rc   = (conv_clock_select[1:0] == CLK_SEL_RC);
  assign div_end  = div_last(conv_clock_select);
  assign bit_tick = tick_ff;

  // Oscillator pin comes from another clock: two stages before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_meta_ff <= 1'b0;
      rc_sync_ff <= 1'b0;
      rc_last_ff <= 1'b0;
    end else begin
      rc_meta_ff <= rc_osc_pin;
      rc_sync_ff <= rc_meta_ff;
      rc_last_ff <= rc_sync_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_cnt_ff <= 6'h00;
      tick_ff    <= 1'b0;
    end else if (use_rc) begin
      div_cnt_ff <= 6'h00;
      tick_ff    <= rc_sync_ff && !rc_last_ff;
    end else if (div_cnt_ff >= div_end) begin
      div_cnt_ff <= 6'h00;
      tick_ff    <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
      tick_ff    <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_gated_off;
    !run |=> !bit_tick;
  endproperty
  a_gated_off: assert property (p_gated_off) else $error("bit tick while converter gated off");

  property p_div2_period;
    (bit_tick && run && conv_clock_select == 3'b000) ##1 (run && conv_clock_select == 3'b000) [*2]
      |-> bit_tick && !$past(bit_tick);
  endproperty
  a_div2_period: assert property (p_div2_period) else $error("divide by two tick spacing wrong");

endmodule
`default_nettype wire

// ### hdl/adcc_core.sv
// Converter control top: AXI4-Lite registers, SAR sequencing, result format, done interrupt
`timescale 1ns/1ps
`default_nettype none
module adcc_core (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [adcc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [adcc_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic                      comp_above_pin,
  input  wire logic                      rc_osc_pin,
  output adcc_pkg::adcc_afe_s            afe,
  output logic [3:0]                     pin_analog_select,
  output logic                           irq
);
  import adcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic              awready_ff;
  logic              wready_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [7:0]        w_byte_ff;
  logic              w_lane0_ff;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_fire;
  logic              wr_en;
  logic              nxt_aw_held;
  logic              nxt_w_held;
  logic              nxt_bvalid;
  logic              ctl_wr;

  adcc_ctrl_s        ctrl_ff;
  logic [2:0]        clk_sel_ff;
  logic [3:0]        pin_sel_ff;
  logic [7:0]        res_hi_ff;
  logic [7:0]        res_lo_ff;
  logic              done_ff;
  logic              done_en_ff;
  logic              irq_ff;
  adcc_afe_s         afe_ff;

  adcc_state_e       state_ff;
  logic [3:0]        cnt_ff;
  logic [9:0]        trial_ff;
  logic [9:0]        nxt_trial;
  logic [3:0]        bit_idx;
  logic              done_pulse_ff;
  logic              conv_finish;
  logic              bit_tick;
  logic              comp_meta_ff;
  logic              comp_sync_ff;
  logic [7:0]        ctrl_word;

  // Helpers read only by assertions
  logic              rd_ctrl_ff;
  logic              rd_conv_ff;
  logic [3:0]        tick_seen_ff;

  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hits = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hits(a, OFF_CONTROL) || hits(a, OFF_ANALOG_CLOCK) || hits(a, OFF_RESULT_HIGH) ||
             hits(a, OFF_RESULT_LOW) || hits(a, OFF_IRQ_STATUS) || hits(a, OFF_IRQ_CLEAR) ||
             hits(a, OFF_IRQ_ENABLE);
  endfunction

  assign awready           = awready_ff;
  assign wready            = wready_ff;
  assign bvalid            = bvalid_ff;
  assign bresp             = bresp_ff;
  assign arready           = arready_ff;
  assign rvalid            = rvalid_ff;
  assign rdata             = rdata_ff;
  assign rresp             = rresp_ff;
  assign afe               = afe_ff;
  assign pin_analog_select = pin_sel_ff;
  assign irq               = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order

  assign aw_hs       = awvalid && awready_ff;
  assign w_hs        = wvalid && wready_ff;
  assign wr_fire     = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_en       = wr_fire && w_lane0_ff && mapped(aw_addr_ff);
  assign nxt_aw_held = (aw_held_ff || aw_hs) && !wr_fire;
  assign nxt_w_held  = (w_held_ff || w_hs) && !wr_fire;
  assign nxt_bvalid  = wr_fire || (bvalid_ff && !bready);
  assign ctl_wr      = wr_en && hits(aw_addr_ff, OFF_CONTROL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      aw_addr_ff <= '0;
      w_byte_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff  <= !nxt_w_held && !nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_hs) begin
        aw_addr_ff <= awaddr;
      end
      if (w_hs) begin
        w_byte_ff  <= wdata[7:0];
        w_lane0_ff <= wstrb[0];
      end
      if (wr_fire) begin
        bresp_ff <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: answer one cycle after the address is taken

  assign ar_hs = arvalid && arready_ff;

  assign ctrl_word = {ctrl_ff.result_justify, ctrl_ff.reference_select, 2'h0,
                      ctrl_ff.channel_select, state_ff == ADCC_CONV, ctrl_ff.converter_on};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (hits(araddr, OFF_CONTROL)) begin
        rdata_ff <= {24'h00_0000, ctrl_word};
      end else if (hits(araddr, OFF_ANALOG_CLOCK)) begin
        rdata_ff <= {24'h00_0000, 1'b0, clk_sel_ff, pin_sel_ff};
      end else if (hits(araddr, OFF_RESULT_HIGH)) begin
        rdata_ff <= {24'h00_0000, res_hi_ff};
      end else if (hits(araddr, OFF_RESULT_LOW)) begin
        rdata_ff <= {24'h00_0000, res_lo_ff};
      end else if (hits(araddr, OFF_IRQ_STATUS)) begin
        rdata_ff <= {31'h0000_0000, done_ff};
      end else if (hits(araddr, OFF_IRQ_ENABLE)) begin
        rdata_ff <= {31'h0000_0000, done_en_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end else if (rvalid_ff && rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff    <= '{result_justify:   CONTROL_RESET[CTL_JUSTIFY_BIT],
                      reference_select: CONTROL_RESET[CTL_REF_BIT],
                      channel_select:   CONTROL_RESET[CTL_CHAN_LSB +: 2],
                      converter_on:     CONTROL_RESET[CTL_ON_BIT]};
      clk_sel_ff <= ANALOG_CLOCK_RESET[ASC_CLK_LSB +: 3];
      pin_sel_ff <= ANALOG_CLOCK_RESET[ASC_PIN_LSB +: 4];
    end else if (wr_en) begin
      if (ctl_wr) begin
        ctrl_ff.result_justify   <= w_byte_ff[CTL_JUSTIFY_BIT];
        ctrl_ff.reference_select <= w_byte_ff[CTL_REF_BIT];
        ctrl_ff.channel_select   <= w_byte_ff[CTL_CHAN_LSB +: 2];
        ctrl_ff.converter_on     <= w_byte_ff[CTL_ON_BIT];
      end
      if (hits(aw_addr_ff, OFF_ANALOG_CLOCK)) begin
        clk_sel_ff <= w_byte_ff[ASC_CLK_LSB +: 3];
        pin_sel_ff <= w_byte_ff[ASC_PIN_LSB +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end else begin
      comp_meta_ff <= comp_above_pin;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  adcc_bit_period u_bit_period (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .run               (ctrl_ff.converter_on && state_ff != ADCC_IDLE),
    .conv_clock_select (clk_sel_ff),
    .rc_osc_pin        (rc_osc_pin),
    .bit_tick          (bit_tick)
  );

  assign bit_idx = CONV_LAST - cnt_ff;

  always_comb begin
    nxt_trial = trial_ff;
    if (cnt_ff != 4'h0) begin
      nxt_trial[bit_idx] = comp_sync_ff;
      if (bit_idx != 4'h0) begin
        nxt_trial[bit_idx - 4'h1] = 1'b1;
      end
    end
  end

  assign conv_finish = (state_ff == ADCC_CONV) && bit_tick && (cnt_ff == CONV_LAST) &&
                       !(ctl_wr && (!w_byte_ff[CTL_GO_BIT] || !w_byte_ff[CTL_ON_BIT]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= ADCC_IDLE;
      cnt_ff        <= 4'h0;
      trial_ff      <= 10'h000;
      done_pulse_ff <= 1'b0;
    end else begin
      done_pulse_ff <= conv_finish;
      if (ctl_wr && !w_byte_ff[CTL_ON_BIT]) begin
        state_ff <= ADCC_IDLE;
        cnt_ff   <= 4'h0;
      end else begin
        case (state_ff)
          ADCC_IDLE: begin
            if (ctl_wr && w_byte_ff[CTL_GO_BIT] && ctrl_ff.converter_on) begin
              state_ff <= ADCC_CONV;
              cnt_ff   <= 4'h0;
              trial_ff <= TRIAL_START;
            end
          end
          ADCC_CONV: begin
            if (ctl_wr && !w_byte_ff[CTL_GO_BIT]) begin
              state_ff <= ADCC_HOLD;
              cnt_ff   <= 4'h0;
            end else if (bit_tick) begin
              trial_ff <= nxt_trial;
              if (conv_finish) begin
                state_ff <= ADCC_IDLE;
                cnt_ff   <= 4'h0;
              end else begin
                cnt_ff <= cnt_ff + 4'h1;
              end
            end
          end
          ADCC_HOLD: begin
            if (bit_tick) begin
              if (cnt_ff == ABORT_LAST) begin
                state_ff <= ADCC_IDLE;
                cnt_ff   <= 4'h0;
              end else begin
                cnt_ff <= cnt_ff + 4'h1;
              end
            end
          end
          default: begin
            state_ff <= ADCC_IDLE;
            cnt_ff   <= 4'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afe_ff <= '0;
    end else begin
      afe_ff.converter_on     <= ctrl_ff.converter_on;
      afe_ff.sample_hold      <= ctrl_ff.converter_on && state_ff == ADCC_IDLE;
      afe_ff.reference_select <= ctrl_ff.reference_select;
      afe_ff.channel_select   <= ctrl_ff.channel_select;
      afe_ff.trial_code       <= trial_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result pair: deliberately no reset, contents survive every reset

  always_ff @(posedge aclk) begin
    if (conv_finish) begin
      if (ctrl_ff.result_justify) begin
        res_hi_ff <= {6'h00, nxt_trial[9:8]};
        res_lo_ff <= nxt_trial[7:0];
      end else begin
        res_hi_ff <= nxt_trial[9:2];
        res_lo_ff <= {nxt_trial[1:0], 6'h00};
      end
    end else if (wr_en) begin
      if (hits(aw_addr_ff, OFF_RESULT_HIGH)) begin
        res_hi_ff <= w_byte_ff;
      end
      if (hits(aw_addr_ff, OFF_RESULT_LOW)) begin
        res_lo_ff <= w_byte_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done interrupt: sticky status, write-one clear, enable

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_ff    <= 1'b0;
      done_en_ff <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      done_ff <= conv_finish ||
                 (done_ff && !(wr_en && hits(aw_addr_ff, OFF_IRQ_CLEAR) && w_byte_ff[IRQ_DONE_BIT]));
      if (wr_en && hits(aw_addr_ff, OFF_IRQ_ENABLE)) begin
        done_en_ff <= w_byte_ff[IRQ_DONE_BIT];
      end
      irq_ff <= done_ff && done_en_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ctrl_ff   <= 1'b0;
      rd_conv_ff   <= 1'b0;
      tick_seen_ff <= 4'h0;
    end else begin
      if (ar_hs) begin
        rd_ctrl_ff <= hits(araddr, OFF_CONTROL);
        rd_conv_ff <= state_ff == ADCC_CONV;
      end
      if (state_ff == ADCC_IDLE) begin
        tick_seen_ff <= 4'h0;
      end else if (state_ff == ADCC_CONV && bit_tick) begin
        tick_seen_ff <= tick_seen_ff + 4'h1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_right_format;
    done_pulse_ff && ctrl_ff.result_justify |-> res_hi_ff[7:2] == 6'h00;
  endproperty
  a_right_format: assert property (p_right_format) else $error("right justified high byte not clear");

  property p_left_format;
    done_pulse_ff && !ctrl_ff.result_justify |-> res_lo_ff[5:0] == 6'h00 && res_hi_ff == $past(trial_ff[9:2]);
  endproperty
  a_left_format: assert property (p_left_format) else $error("left justified result misplaced");

  property p_ctrl_unimpl;
    rvalid_ff && rd_ctrl_ff |-> rdata_ff[5:4] == 2'h0;
  endproperty
  a_ctrl_unimpl: assert property (p_ctrl_unimpl) else $error("control bits 5-4 read nonzero");

  property p_go_busy;
    rvalid_ff && rd_ctrl_ff && rd_conv_ff |-> rdata_ff[CTL_GO_BIT];
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("go read low during conversion");

  property p_eleven_periods;
    done_pulse_ff |-> tick_seen_ff == CONV_BIT_PERIODS;
  endproperty
  a_eleven_periods: assert property (p_eleven_periods) else $error("conversion not eleven bit periods");

  property p_completion;
    done_pulse_ff |-> done_ff && state_ff == ADCC_IDLE && !$past(state_ff == ADCC_IDLE);
  endproperty
  a_completion: assert property (p_completion) else $error("completion did not set done and clear go");

  property p_abort_keeps;
    state_ff == ADCC_HOLD && !wr_en |=> $stable(res_hi_ff) && $stable(res_lo_ff) && !done_pulse_ff;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed result");

  property p_off_idle;
    !ctrl_ff.converter_on |-> state_ff == ADCC_IDLE ##1 !done_pulse_ff;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("conversion ran while off");

  property p_irq_level;
    done_ff && done_en_ff |=> irq_ff;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("enabled done did not raise interrupt");

endmodule
`default_nettype wire

// ### tb/adcc_analog_model.sv
// Analog side model: comparator answer from four fixed channel levels
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model #(
  parameter logic [39:0] LEVELS = 40'h0
) (
  input  wire adcc_pkg::adcc_afe_s afe,
  output logic                     comp_above_pin,
  output logic                     rc_osc_pin
);
  import adcc_pkg::*;
  assign comp_above_pin = afe.converter_on & (LEVELS[afe.channel_select*10 +: 10] >= afe.trial_code);
  // Free running, unrelated to aclk; five aclk per period so the comparator settles between bit periods
  initial rc_osc_pin = 1'b0;
  always #100 rc_osc_pin = ~rc_osc_pin;
endmodule
`default_nettype wire

// ### tb/adc_control_result_format_test.sv
// Register level bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module adc_control_result_format_test;
  import adcc_pkg::*;
  localparam logic [39:0] LEVELS = {10'h001, 10'h3FF, 10'h15A, 10'h2A5};
  logic             aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready, comp_above_pin, rc_osc_pin, irq;
  logic [7:0]       awaddr, araddr, c;
  logic [31:0]      wdata, rdata, d, hi, lo;
  logic [3:0]       wstrb, pin_analog_select;
  logic [1:0]       bresp, rresp, br, rr;
  logic [9:0]       v;
  adcc_afe_s        afe;
  int               fails, checked, i, n, k;
  adcc_core dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .comp_above_pin,
    .rc_osc_pin, .afe, .pin_analog_select, .irq);
  adcc_analog_model #(.LEVELS(LEVELS)) model (.afe, .comp_above_pin, .rc_osc_pin);
  always #20 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    awaddr <= a;
    wdata <= {24'h0, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 100);
    br = bresp;
    if (n >= 100) begin fails++; stop_test(); end
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    rr = rresp;
    if (n >= 100) begin fails++; stop_test(); end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3F;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFF_CONTROL); `CHK(d, 32'h0)
    rd(OFF_ANALOG_CLOCK); `CHK(d, 32'hF)
    `CHK(pin_analog_select, 4'hF)
    wr(OFF_CONTROL, 8'hFF);
    rd(OFF_CONTROL); `CHK(d, 32'hCD)
    wr(OFF_ANALOG_CLOCK, 8'h2F);
    wr(OFF_IRQ_ENABLE, 8'h01);
    // Last two passes run on divide by four and on the RC oscillator
    for (i = 0; i < 6; i++) begin
      c = {i[0], i[1], 2'b00, i[1:0], 2'b01};
      v = LEVELS[i[1:0]*10 +: 10];
      if (i == 3) wr(OFF_IRQ_ENABLE, 8'h00);
      if (i == 4) wr(OFF_ANALOG_CLOCK, 8'h4F);
      if (i == 5) wr(OFF_ANALOG_CLOCK, 8'h3F);
      wr(OFF_CONTROL, c);
      repeat (20) @(posedge aclk);
      wr(OFF_CONTROL, c | 8'h02);
      rd(OFF_CONTROL); `CHK(d, {24'h0, c | 8'h02})
      `CHK(afe.channel_select, i[1:0])
      `CHK(afe.reference_select, i[1])
      if (i == 0) begin
        repeat (288) @(posedge aclk);
        rd(OFF_CONTROL); `CHK(d[1], 1'b1)
      end
      k = 0;
      do begin
        rd(OFF_CONTROL);
        k++;
      end while (d[1] && k < 400);
      `CHK(d[1], 1'b0)
      `CHK(irq, i < 3)
      rd(OFF_IRQ_STATUS); `CHK(d, 32'h1)
      rd(OFF_RESULT_HIGH); hi = d;
      rd(OFF_RESULT_LOW); lo = d;
      if (i[0]) begin
        `CHK(hi & 32'h3, {30'h0, v[9:8]})
        `CHK(lo, {24'h0, v[7:0]})
      end else begin
        `CHK(hi, {24'h0, v[9:2]})
        `CHK(lo & 32'hC0, {24'h0, v[1:0], 6'h0})
      end
      wr(OFF_IRQ_CLEAR, 8'h01);
      rd(OFF_IRQ_STATUS); `CHK(d, 32'h0)
    end
    // Slow clock again so the abort lands mid-conversion
    wr(OFF_ANALOG_CLOCK, 8'h2F);
    wr(OFF_CONTROL, 8'h03);
    repeat (100) @(posedge aclk);
    wr(OFF_CONTROL, 8'h01);
    rd(OFF_CONTROL); `CHK(d, 32'h1)
    rd(OFF_IRQ_STATUS); `CHK(d, 32'h0)
    rd(OFF_RESULT_HIGH); `CHK(d, hi)
    rd(OFF_RESULT_LOW); `CHK(d, lo)
    wr(OFF_CONTROL, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK(afe.converter_on, 1'b0)
    wr(8'h1C, 8'h55); `CHK(br, RESP_SLVERR)
    rd(8'h1C); `CHK(rr, RESP_SLVERR)
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFF_RESULT_HIGH); `CHK(d, hi)
    rd(OFF_RESULT_LOW); `CHK(d, lo)
    stop_test();
  end
endmodule
`default_nettype wire
